// file: logic/ssfc_pkg.sv
// Constants for the switching-regulator sequencing and fault control block.
// Assumes a 50 MHz pclk and APB register access with 32-bit data.
package ssfc_pkg;

  // Regulator index: 0 main (A), 1 small (B), 2 large (C)
  localparam int NREG = 3;

  // Clock and switching-frequency settings
  localparam int CLK_HZ      = 50_000_000;
  localparam int FSW_B_LO_HZ = 500_000;
  localparam int FSW_B_MD_HZ = 750_000;
  localparam int FSW_B_HI_HZ = 1_000_000;
  localparam logic [6:0] DIV_LO = 7'(CLK_HZ / FSW_B_LO_HZ);
  localparam logic [6:0] DIV_MD = 7'(CLK_HZ / FSW_B_MD_HZ);
  localparam logic [6:0] DIV_HI = 7'(CLK_HZ / FSW_B_HI_HZ);

  // Strap encodings
  localparam logic [1:0] STRAP_5V   = 2'h0;
  localparam logic [1:0] STRAP_REF  = 2'h1;
  localparam logic [1:0] STRAP_GND  = 2'h2;
  localparam logic [1:0] STRAP_SYNC = 2'h3;

  // Soft-start and blanking lengths in switching cycles
  localparam logic [11:0] SS_LEN_A    = 12'h4B0;
  localparam logic [11:0] SS_LEN_B    = 12'h708;
  localparam logic [11:0] SS_LEN_C    = 12'h384;
  localparam logic [11:0] BLANK_LEN_AC = 12'h5DC;
  localparam logic [11:0] BLANK_LEN_B  = 12'hBB8;
  localparam logic [4:0]  STEP_CYC_A  = 5'h0C;
  localparam logic [4:0]  STEP_CYC_B  = 5'h18;
  localparam logic [4:0]  STEP_CYC_C  = 5'h18;

  // APB register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLKSEL = 8'h08;
  localparam logic [2:0] CTRL_RESET  = 3'h7;

  // Switching phase of one regulator
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ON   = 3'b010,
    PH_OFF  = 3'b100
  } ssfc_phase_t;

  function automatic logic [11:0] ss_len(input int i);
    ss_len = (i == 0) ? SS_LEN_A : (i == 1) ? SS_LEN_B : SS_LEN_C;
  endfunction : ss_len

  function automatic logic [11:0] blank_len(input int i);
    blank_len = (i == 1) ? BLANK_LEN_B : BLANK_LEN_AC;
  endfunction : blank_len

  function automatic logic [4:0] step_cyc(input int i);
    step_cyc = (i == 0) ? STEP_CYC_A : (i == 1) ? STEP_CYC_B : STEP_CYC_C;
  endfunction : step_cyc

endpackage : ssfc_pkg

// file: logic/ssfc_top.sv
// Sequencing, soft-start, power-good and fault control for three regulators.
// Assumes comparator inputs synchronous to pclk and an APB master.
//
// Summary of operation
// - Strap picks A/C and B switching frequency
// - Sync strap: B at sync, A/C half
// - A soft-start: step per 12 cycles, 1200
// - C soft-start: step per 24 cycles, 900
// - B soft-start completes after 1800 cycles
// - UV monitor after 1500/3000 cycle blanking
// - Power-on clears latches, low gates low
// - Bias lockout inhibits all switching
// - A starts on bias ok and enable
// - B/C need both lockouts, shutdown, enable
// - Bias loss stops B/C, nodes high-Z
// - A disabled: both gates low
// - B/C disabled: switch node high-Z
// - Zero crossing ends low-side on-time
// - Zero-cross comparators per regulator type
// - Skip: on-time ends feedback and idle
// - Power-good low shutdown, standby, soft-start
// - Power-good window, low on undervoltage
// - Overvoltage latches, holds low-side on
// - Bias cycle or enable toggle clears
// - Undervoltage latches, gates low, shutdown
// - Thermal latch stops all, shutdown clears
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module ssfc_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System pins
  input  wire logic [1:0]  strap_a,
  input  wire logic        ext_sync,
  input  wire logic        bias_por,
  input  wire logic        bias_lockout,
  input  wire logic        internal_reg_supply_ok,
  input  wire logic        shutdown_n,
  input  wire logic        enable_main_reg,
  input  wire logic        enable_small_reg,
  input  wire logic        enable_large_reg,
  input  wire logic        thermal_trip,
  // Analog comparators, index 0 main, 1 small, 2 large
  input  wire logic [2:0]  overvoltage_trip,
  input  wire logic [2:0]  undervoltage_trip,
  input  wire logic [2:0]  window_ok,
  input  wire logic [2:0]  fb_above,
  input  wire logic [2:0]  idle_cur_above,
  input  wire logic [2:0]  zero_cross,
  // Gate drives and switch nodes
  output logic             main_high_gate,
  output logic             main_low_gate,
  output logic      [1:0]  int_high_gate,
  output logic      [1:0]  int_low_gate,
  output logic      [1:0]  internal_switch_node_en,
  output logic      [23:0] ss_target,
  // Open-drain power-good pins
  input  wire logic [2:0]  power_good_in,
  output logic      [2:0]  power_good_o,
  output logic      [2:0]  power_good_oe
);

  localparam int NREG_L = ssfc_pkg::NREG;

  logic [6:0]  div_q;
  logic        b_tick_q;
  logic        half_q;
  logic        sync_prev_q;
  logic [2:0]  en_prev_q;
  logic        sd_prev_q;
  logic        therm_q;
  logic [2:0]  ov_q;
  logic [2:0]  uv_q;
  logic [2:0]  sw_en_q;
  logic [11:0] cyc_q  [NREG_L];
  logic [4:0]  stc_q  [NREG_L];
  logic [7:0]  code_q [NREG_L];
  ssfc_pkg::ssfc_phase_t ph_q [NREG_L];
  logic [2:0]  hs_q;
  logic [2:0]  ls_q;
  logic [2:0]  drv_q;
  logic [2:0]  pg_oe_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  logic [2:0]  en_pin;
  logic [2:0]  en_v;
  logic [2:0]  lock_ok;
  logic [2:0]  run;
  logic [2:0]  tick;
  logic [2:0]  ss_done;
  logic [2:0]  blank_done;
  logic [2:0]  en_fall;
  logic [6:0]  div_len;
  logic        ac_tick;
  logic        standby;
  logic        bias_ok;
  logic        sd_rise;
  logic        apb_acc;
  logic        addr_ok;
  // Fault entry in the current cycle
  logic [2:0]  ov_set;
  logic [2:0]  uv_set;
  logic [2:0]  stop;
  logic [2:0]  clamp;
  logic        hot;

  // Run conditions and switching ticks
  always_comb begin
    en_pin  = {enable_large_reg, enable_small_reg, enable_main_reg};
    en_v    = en_pin & sw_en_q;
    bias_ok = bias_por & ~bias_lockout;
    standby = ~|en_pin;
    sd_rise = shutdown_n & ~sd_prev_q;
    en_fall = en_prev_q & ~en_pin;
    ac_tick = b_tick_q & half_q;
    for (int i = 0; i < NREG_L; i++) begin
      // A needs only the bias; B and C also their supply and shutdown_n high
      if (i == 0) begin
        lock_ok[i] = bias_ok;
      end else begin
        lock_ok[i] = bias_ok & internal_reg_supply_ok & shutdown_n;
      end
      run[i]        = en_v[i] & lock_ok[i] & ~ov_q[i] & ~uv_q[i] & ~therm_q;
      tick[i]       = (i == 1) ? b_tick_q : ac_tick;
      ss_done[i]    = cyc_q[i] >= ssfc_pkg::ss_len(i);
      blank_done[i] = cyc_q[i] >= ssfc_pkg::blank_len(i);
    end
    case (strap_a)
      ssfc_pkg::STRAP_5V:  div_len = ssfc_pkg::DIV_LO;
      ssfc_pkg::STRAP_REF: div_len = ssfc_pkg::DIV_MD;
      default:             div_len = ssfc_pkg::DIV_HI;
    endcase
  end

  // Faults seen this cycle, so drives react one clock after the comparator
  always_comb begin
    hot = bias_por & thermal_trip;
    for (int i = 0; i < NREG_L; i++) begin
      ov_set[i] = run[i] & overvoltage_trip[i];
      uv_set[i] = run[i] & blank_done[i] & undervoltage_trip[i];
      stop[i]   = ~run[i] | ov_set[i] | uv_set[i] | hot;
      clamp[i]  = (ov_q[i] | ov_set[i]) & en_v[i] & bias_ok & ~therm_q & ~hot;
    end
  end

  // Switching clock: internal divider or external sync edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q       <= 7'h00;
      b_tick_q    <= 1'b0;
      half_q      <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= ext_sync;
      // Sync strap: one switching cycle per rising sync edge
      if (strap_a == ssfc_pkg::STRAP_SYNC) begin
        div_q    <= 7'h00;
        b_tick_q <= ext_sync & ~sync_prev_q;
      end else if (div_q >= div_len - 7'h01) begin
        div_q    <= 7'h00;
        b_tick_q <= 1'b1;
      end else begin
        div_q    <= div_q + 7'h01;
        b_tick_q <= 1'b0;
      end
      if (b_tick_q) begin
        half_q <= ~half_q;
      end
    end
  end

  // Edge history of enables and shutdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_q <= 3'h0;
      // High so a released shutdown is no false rising edge
      sd_prev_q <= 1'b1;
    end else begin
      en_prev_q <= en_pin;
      sd_prev_q <= shutdown_n;
    end
  end

  // Fault latches; a new trip wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_q    <= 3'h0;
      uv_q    <= 3'h0;
      therm_q <= 1'b0;
    end else begin
      for (int i = 0; i < NREG_L; i++) begin
        if (ov_set[i]) begin
          ov_q[i] <= 1'b1;
        end else if (!bias_por || en_fall[i]) begin
          ov_q[i] <= 1'b0;
        end
        if (uv_set[i]) begin
          uv_q[i] <= 1'b1;
        end else if (!bias_por || en_fall[i]) begin
          uv_q[i] <= 1'b0;
        end
      end
      // Thermal clears on a shutdown rising edge once cool, or on bias_por low
      if (hot) begin
        therm_q <= 1'b1;
      end else if (!bias_por || (sd_rise && !thermal_trip)) begin
        therm_q <= 1'b0;
      end
    end
  end

  // Soft-start and blanking counters, cleared whenever not running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG_L; i++) begin
        cyc_q[i]  <= 12'h000;
        stc_q[i]  <= 5'h00;
        code_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NREG_L; i++) begin
        if (!run[i]) begin
          cyc_q[i]  <= 12'h000;
          stc_q[i]  <= 5'h00;
          code_q[i] <= 8'h00;
        end else if (tick[i]) begin
          // Blanking count stops at its end, never wraps
          if (!blank_done[i]) begin
            cyc_q[i] <= cyc_q[i] + 12'h001;
          end
          if (!ss_done[i]) begin
            if (stc_q[i] == ssfc_pkg::step_cyc(i) - 5'h01) begin
              stc_q[i]  <= 5'h00;
              code_q[i] <= code_q[i] + 8'h01;
            end else begin
              stc_q[i] <= stc_q[i] + 5'h01;
            end
          end
        end
      end
    end
  end

  // Per-regulator switching phase and gate drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG_L; i++) begin
        ph_q[i] <= ssfc_pkg::PH_IDLE;
      end
      hs_q  <= 3'h0;
      ls_q  <= 3'h0;
      drv_q <= 3'h0;
    end else begin
      for (int i = 0; i < NREG_L; i++) begin
        // A fault seen this cycle stops the drives at once
        if (stop[i]) begin
          ph_q[i]  <= ssfc_pkg::PH_IDLE;
          hs_q[i]  <= 1'b0;
          // Enable low wins over the clamp, so B/C switch nodes float and both A gates go low
          ls_q[i]  <= clamp[i];
          drv_q[i] <= clamp[i];
        end else begin
          drv_q[i] <= 1'b1;
          case (ph_q[i])
            ssfc_pkg::PH_IDLE: begin
              ls_q[i] <= 1'b0;
              if (tick[i] && !fb_above[i]) begin
                ph_q[i] <= ssfc_pkg::PH_ON;
                hs_q[i] <= 1'b1;
              end
            end
            ssfc_pkg::PH_ON: begin
              if ((fb_above[i] && idle_cur_above[i]) || tick[i]) begin
                ph_q[i] <= ssfc_pkg::PH_OFF;
                hs_q[i] <= 1'b0;
                ls_q[i] <= 1'b1;
              end
            end
            ssfc_pkg::PH_OFF: begin
              if (zero_cross[i]) begin
                ph_q[i] <= ssfc_pkg::PH_IDLE;
                ls_q[i] <= 1'b0;
              end else if (tick[i] && !fb_above[i]) begin
                ph_q[i] <= ssfc_pkg::PH_ON;
                hs_q[i] <= 1'b1;
                ls_q[i] <= 1'b0;
              end
            end
            default: begin
              ph_q[i] <= ssfc_pkg::PH_IDLE;
              hs_q[i] <= 1'b0;
              ls_q[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Power-good: release only in window after soft-start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_oe_q <= 3'h7;
    end else begin
      for (int i = 0; i < NREG_L; i++) begin
        if (!shutdown_n || standby || !run[i] || !ss_done[i] || hot) begin
          pg_oe_q[i] <= 1'b1;
        end else if (undervoltage_trip[i] || overvoltage_trip[i]) begin
          pg_oe_q[i] <= 1'b1;
        end else if (window_ok[i]) begin
          pg_oe_q[i] <= 1'b0;
        end
      end
    end
  end

  // APB slave, no wait states on any access
  always_comb begin
    apb_acc = psel & penable & pready_q;
    addr_ok = (paddr == ssfc_pkg::ADDR_CTRL) || (paddr == ssfc_pkg::ADDR_STATUS)
           || (paddr == ssfc_pkg::ADDR_CLKSEL);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      sw_en_q   <= ssfc_pkg::CTRL_RESET;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~addr_ok;
      // Read data latched at setup, held until the next read
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ssfc_pkg::ADDR_CTRL:   prdata_q <= {29'h0, sw_en_q};
          ssfc_pkg::ADDR_STATUS: prdata_q <= {13'h0, ~pg_oe_q, therm_q, uv_q, ov_q,
                                              ss_done, blank_done, run};
          ssfc_pkg::ADDR_CLKSEL: prdata_q <= {23'h0, div_len, strap_a};
          default:               prdata_q <= 32'h0000_0000;
        endcase
      end
      if (apb_acc && pwrite && paddr == ssfc_pkg::ADDR_CTRL) begin
        sw_en_q <= pwdata[2:0];
      end
    end
  end

  // Outputs straight from flip-flops
  assign prdata                  = prdata_q;
  assign pready                  = pready_q;
  assign pslverr                 = pslverr_q;
  assign main_high_gate          = hs_q[0];
  assign main_low_gate           = ls_q[0];
  assign int_high_gate           = hs_q[2:1];
  assign int_low_gate            = ls_q[2:1];
  assign internal_switch_node_en = drv_q[2:1];
  assign ss_target               = {code_q[2], code_q[1], code_q[0]};
  // Open drain: level fixed low, enable pulls the pin
  assign power_good_o            = 3'h0;
  assign power_good_oe           = pg_oe_q;

endmodule : ssfc_top

// file: sim/ssfc_checker.sv
// Port-level assertions for the regulator sequencing and fault block.
// Assumes only the top module's ports; bound to it below.
`timescale 1ns/1ps
module ssfc_checker (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // System pins
  input wire logic       bias_por,
  input wire logic       bias_lockout,
  input wire logic       internal_reg_supply_ok,
  input wire logic       shutdown_n,
  input wire logic       enable_main_reg,
  input wire logic       enable_small_reg,
  input wire logic       enable_large_reg,
  input wire logic       thermal_trip,
  // Comparators
  input wire logic [2:0] overvoltage_trip,
  input wire logic [2:0] undervoltage_trip,
  input wire logic [2:0] fb_above,
  // Drives
  input wire logic       main_high_gate,
  input wire logic       main_low_gate,
  input wire logic [1:0] int_high_gate,
  input wire logic [1:0] int_low_gate,
  input wire logic [1:0] internal_switch_node_en,
  input wire logic [2:0] power_good_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [5:0] gates = {main_high_gate, main_low_gate, int_high_gate, int_low_gate};
  // Large regulator running when its overvoltage trips
  wire logic       ovc = overvoltage_trip[2] & internal_switch_node_en[1] & enable_large_reg
                         & bias_por & ~bias_lockout & ~thermal_trip & shutdown_n
                         & internal_reg_supply_ok & ~undervoltage_trip[2];
  lockout_gates_a: assert property (
    bias_lockout |=> gates == 6'h00) else $error("gate on in lockout");
  lockout_hiz_a: assert property (
    bias_lockout |=> internal_switch_node_en == 2'h0) else $error("node driven in lockout");
  por_low_a: assert property (
    !bias_por |=> !main_low_gate && int_low_gate == 2'h0) else $error("low gate on at por");
  main_off_a: assert property (
    !enable_main_reg |=> !main_high_gate && !main_low_gate) else $error("main gate on");
  small_hiz_a: assert property (
    !enable_small_reg |=> !internal_switch_node_en[0]) else $error("small node driven");
  large_hiz_a: assert property (
    !enable_large_reg |=> !internal_switch_node_en[1]) else $error("large node driven");
  shutdown_pg_a: assert property (
    !shutdown_n |=> power_good_oe == 3'h7) else $error("good released in shutdown");
  standby_pg_a: assert property (
    !(enable_main_reg | enable_small_reg | enable_large_reg) |=> power_good_oe == 3'h7)
    else $error("good released in standby");
  thermal_stop_a: assert property (
    thermal_trip |=> power_good_oe == 3'h7 && !main_high_gate && int_high_gate == 2'h0)
    else $error("running when hot");
  ov_good_a: assert property (
    overvoltage_trip[0] |=> power_good_oe[0]) else $error("good released on overvoltage");
  ov_clamp_a: assert property (
    ovc |=> int_low_gate[1] && !int_high_gate[1] && internal_switch_node_en[1])
    else $error("no clamp on overvoltage");
  skip_start_a: assert property (
    $rose(main_high_gate) |-> !$past(fb_above[0])) else $error("on-time above threshold");
  cover property ($rose(main_high_gate));
  cover property ($fell(power_good_oe[0]));
  cover property (ovc);
endmodule : ssfc_checker

bind ssfc_top ssfc_checker u_chk (
  .pclk(pclk), .presetn(presetn), .bias_por(bias_por), .bias_lockout(bias_lockout),
  .internal_reg_supply_ok(internal_reg_supply_ok), .shutdown_n(shutdown_n),
  .enable_main_reg(enable_main_reg), .enable_small_reg(enable_small_reg),
  .enable_large_reg(enable_large_reg), .thermal_trip(thermal_trip),
  .overvoltage_trip(overvoltage_trip), .undervoltage_trip(undervoltage_trip),
  .fb_above(fb_above), .main_high_gate(main_high_gate), .main_low_gate(main_low_gate),
  .int_high_gate(int_high_gate), .int_low_gate(int_low_gate),
  .internal_switch_node_en(internal_switch_node_en), .power_good_oe(power_good_oe));

// file: sim/ssfc_stage_model.sv
// Behavioural power stage: output level, current and fault comparators.
// Assumes gate drives index 0 main, 1 small, 2 large.
`timescale 1ns/1ps
module ssfc_stage_model (
  // Clock
  input  wire logic       pclk,
  // Gate drives
  input  wire logic [2:0] hs,
  input  wire logic [2:0] ls,
  // Fault requests
  input  wire logic [2:0] ov_req,
  input  wire logic [2:0] uv_req,
  // Comparators
  output logic      [2:0] overvoltage_trip,
  output logic      [2:0] undervoltage_trip,
  output logic      [2:0] window_ok,
  output logic      [2:0] fb_above,
  output logic      [2:0] idle_cur_above,
  output logic      [2:0] zero_cross
);
  // Output rises while on, holds while freewheeling
  always_ff @(posedge pclk) begin
    fb_above       <= hs | (fb_above & ls);
    idle_cur_above <= hs;
    zero_cross     <= ls;
  end
  assign overvoltage_trip  = ov_req;
  assign undervoltage_trip = uv_req;
  assign window_ok         = ~(ov_req | uv_req);
endmodule : ssfc_stage_model

// file: sim/testbench.sv
// Self-checking bench: APB accesses, pin stimulus, power stage model.
// Assumes the block's package and top module are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, ext_sync, bias_por, bias_lockout, err;
  logic        supply_ok, shutdown_n, enable_main_reg, enable_small_reg, enable_large_reg;
  logic        thermal_trip, pready, pslverr, main_high_gate, main_low_gate;
  logic [1:0]  strap_a, int_high_gate, int_low_gate, internal_switch_node_en;
  logic [2:0]  ov_req, uv_req, ovt, uvt, win, fba, ica, zc, power_good_oe;
  logic [7:0]  paddr;
  logic [23:0] ss_target;
  logic [31:0] pwdata, prdata, q;
  logic [6:0]  dv [3] = '{7'h64, 7'h42, 7'h32};
  int          failures = 0, checks = 0, cyc = 0, t0, t1;

  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc      <= cyc + 1;
    ext_sync <= ~ext_sync;
  end

  ssfc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_a(strap_a), .ext_sync(ext_sync), .bias_por(bias_por), .bias_lockout(bias_lockout),
    .internal_reg_supply_ok(supply_ok), .shutdown_n(shutdown_n),
    .enable_main_reg(enable_main_reg), .enable_small_reg(enable_small_reg),
    .enable_large_reg(enable_large_reg), .thermal_trip(thermal_trip),
    .overvoltage_trip(ovt), .undervoltage_trip(uvt), .window_ok(win), .fb_above(fba),
    .idle_cur_above(ica), .zero_cross(zc), .main_high_gate(main_high_gate),
    .main_low_gate(main_low_gate), .int_high_gate(int_high_gate), .int_low_gate(int_low_gate),
    .internal_switch_node_en(internal_switch_node_en), .ss_target(ss_target),
    .power_good_in(~power_good_oe), .power_good_o(), .power_good_oe(power_good_oe));

  ssfc_stage_model u_stage (
    .pclk(pclk), .hs({int_high_gate, main_high_gate}), .ls({int_low_gate, main_low_gate}),
    .ov_req(ov_req), .uv_req(uv_req), .overvoltage_trip(ovt), .undervoltage_trip(uvt),
    .window_ok(win), .fb_above(fba), .idle_cur_above(ica), .zero_cross(zc));

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) begin
      failures++;
      results();
    end
  endtask : apb

  task automatic poll(input int b, output int t);
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 3000);
    t = cyc - t0;
    if (n >= 3000) begin
      failures++;
      results();
    end
  endtask : poll

  initial begin
    {presetn, psel, penable, pwrite, ext_sync, bias_lockout, thermal_trip} = 7'h00;
    {enable_main_reg, enable_small_reg, enable_large_reg, ov_req, uv_req} = 9'h000;
    {bias_por, supply_ok, shutdown_n, strap_a, paddr, pwdata} = {3'h7, 42'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("pg_oe", 3'h7, power_good_oe)
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl", 32'h0000_0007, q)
    for (int s = 0; s < 3; s++) begin
      strap_a <= s[1:0];
      apb(1'b0, 8'h08, 32'h0);
      `CHK("clksel", {dv[s], s[1:0]}, q[8:0])
    end
    apb(1'b1, 8'h0C, 32'h5);
    `CHK("slverr", 1'b1, err)
    strap_a <= 2'h3;
    {enable_main_reg, enable_small_reg, enable_large_reg} <= 3'h7;
    t0 = cyc;
    repeat (20) @(posedge pclk);
    `CHK("pg_ss", 3'h7, power_good_oe)
    apb(1'b0, 8'h04, 32'h0);
    `CHK("run", 3'h7, q[2:0])
    poll(8, t1);
    `CHK("ss_c", 1'b1, (t1 - 3600) inside {[-16:16]})
    `CHK("code_c", 8'h25, ss_target[23:16])
    poll(7, t1);
    `CHK("ss_b", 1'b1, (t1 - 3600) inside {[-16:16]})
    `CHK("code_b", 8'h4B, ss_target[15:8])
    poll(6, t1);
    `CHK("ss_a", 1'b1, (t1 - 4800) inside {[-16:16]})
    `CHK("code_a", 8'h64, ss_target[7:0])
    repeat (4) @(posedge pclk);
    `CHK("pg_up", 3'h0, power_good_oe)
    uv_req <= 3'h1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("uv_early", 2'h1, {q[12], power_good_oe[0]})
    poll(3, t1);
    `CHK("blank", 1'b1, (t1 - 6000) inside {[-16:16]})
    apb(1'b0, 8'h04, 32'h0);
    `CHK("uv_stat", 6'h0E, {q[14:12], q[2:0]})
    `CHK("uv_pins", 3'h1, {main_high_gate, main_low_gate, power_good_oe[0]})
    uv_req <= 3'h0;
    enable_main_reg <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("ss_clr", 8'h00, ss_target[7:0])
    enable_main_reg <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("uv_clr", 2'h1, {q[12], q[0]})
    ov_req <= 3'h4;
    repeat (3) @(posedge pclk);
    `CHK("ov_pins", 4'hB, {int_low_gate[1], int_high_gate[1], internal_switch_node_en[1],
                          power_good_oe[2]})
    apb(1'b0, 8'h04, 32'h0);
    `CHK("ov_stat", 2'h3, {q[11], q[1]})
    ov_req <= 3'h0;
    enable_large_reg <= 1'b0;
    @(posedge pclk);
    enable_large_reg <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("ov_clr", 1'b0, q[11])
    thermal_trip <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("hot", 7'h78, {q[15], power_good_oe, q[2:0]})
    thermal_trip <= 1'b0;
    shutdown_n <= 1'b0;
    repeat (2) @(posedge pclk);
    shutdown_n <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("hot_clr", 1'b0, q[15])
    bias_lockout <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("lockout", 8'h00, {internal_switch_node_en, main_high_gate, main_low_gate,
                           int_high_gate, int_low_gate})
    bias_lockout <= 1'b0;
    repeat (3) @(posedge pclk);
    ov_req <= 3'h2;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("ov_b", 1'b1, q[10])
    ov_req <= 3'h0;
    bias_por <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("por_low", 3'h0, {main_low_gate, int_low_gate})
    bias_por <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    `CHK("por_clr", 7'h00, q[15:9])
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl_wr", 32'h0000_0006, q)
    apb(1'b0, 8'h04, 32'h0);
    `CHK("mask_off", 4'h1, {q[0], main_high_gate, main_low_gate, power_good_oe[0]})
    results();
  end
endmodule : testbench
